// >>> verilog/ccf_map.svh
// Constants of the contactless card front end: framing, CRC, commands, limits
`ifndef CCF_MAP_SVH
`define CCF_MAP_SVH
`define CCF_CLK_MHZ 125
`define CCF_LINK_TIMEOUT_US 100
`define CCF_LINK_TIMEOUT_CYC (`CCF_LINK_TIMEOUT_US * `CCF_CLK_MHZ)
`define CCF_SOF_LOW_BITS 4'hA
`define CCF_SOF_BITS 4'hC
`define CCF_EOF_LOW_BITS 4'hA
`define CCF_CHAR_BITS 4'hA
`define CCF_CRC_BYTES 6'h02
`define CCF_CRC_INIT 16'hFFFF
`define CCF_CRC_POLY 16'h8408
`define CCF_CRC_RESIDUE 16'hF0B8
`define CCF_PAGE_BYTES 9'h020
`define CCF_APF 8'h05
`define CCF_WUP_BIT 3
`define CCF_ATQB_HDR 8'h50
`define CCF_CMD_HALT 8'h50
`define CCF_CMD_ATTRIB 8'h1D
`define CCF_CMD_READ 8'h02
`define CCF_CMD_WRITE 8'h03
`define CCF_CMD_CFG_READ 8'h06
`define CCF_CMD_CFG_WRITE 8'h07
`define CCF_CMD_FUSE 8'h04
`define CCF_ST_ACK 8'h00
`define CCF_ST_PAGE 8'h01
`define CCF_ST_SEC 8'h02
`define CCF_ST_FUSE 8'h03
`define CCF_ST_LEN 8'h04
`define CCF_FUSE0_END 8'h40
`define CCF_FUSE1_END 8'h80
`define CCF_FUSE2_END 8'hC0
`endif

// >>> verilog/ccf_pkg.sv
// Types of the contactless card front end
package ccf_pkg;
	typedef enum logic [5:0] {
		CS_OFF = 6'h01, CS_TEAR = 6'h02, CS_IDLE = 6'h04,
		CS_READY = 6'h08, CS_ACTIVE = 6'h10, CS_HALT = 6'h20
	} ccf_card_t;
	typedef enum logic [2:0] {RX_IDLE = 3'h1, RX_WAIT = 3'h2, RX_BITS = 3'h4} ccf_rx_t;
	typedef enum logic [3:0] {TX_IDLE = 4'h1, TX_SOF = 4'h2, TX_CHAR = 4'h4, TX_EOF = 4'h8} ccf_tx_t;
	typedef enum logic [2:0] {
		MODE_STANDARD = 3'h1, MODE_AUTH = 3'h2, MODE_ENCRYPT = 3'h4
	} ccf_mode_t;
	typedef struct packed {
		logic valid;
		logic write;
		logic cfg;
		logic [3:0] zone;
		logic [7:0] addr;
		logic [5:0] len;
	} ccf_mem_req_t;
endpackage

// >>> verilog/ccf_front_end.sv
// Contactless card front end: framing, CRC_B, polling states, memory and fuse gating
`include "ccf_map.svh"

// Operation
// - on field entry reset, then stay silent until a valid polling command
// - evaluate anti-tearing state during power-on before answering polls
// - WUPB with matching AFI activates the card, even when halted
// - REQB acts like WUPB but a halted card ignores it
// - memory and security commands refused until anticollision completes
// - half-duplex frame exchange at 106 kbit/s
// - every frame carries a two-byte CRC_B
// - CRC_B covers command and data bytes only
// - SOF, EOF, start, stop bits and guard time excluded from CRC_B
// - frame order is SOF, data, CRC1, CRC2, EOF
// - Type A signalling gets no response and causes no lock-up
// - sixteen zones of 256 bytes, addressed by zone and byte address
// - multi-byte writes stay within one 32-byte page
// - user-zone access refused until its security conditions are met
// - 2048-bit configuration area with fixed access rights
// - three fuses blown only in order, each locking configuration memory
// - after anticollision the card starts in standard mode
module ccf_front_end
	import ccf_pkg::*;
#(
	parameter int MaxBytes = 36,
	parameter int LinkTimeoutCyc = `CCF_LINK_TIMEOUT_CYC
)
(
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic fieldOn,
	input wire logic linkClk,
	input wire logic rxBit,
	input wire logic typeAMod,
	input wire logic tearDone,
	input wire logic [7:0] cfgAfi,
	input wire logic [31:0] cardId,
	input wire logic [15:0] zoneReadOk,
	input wire logic [15:0] zoneWriteOk,
	input wire logic cfgWriteOk,
	input wire logic [2:0] fuseBlown,
	output logic txBit_ff,
	output logic txActive_ff,
	output logic tearReq_ff,
	output ccf_mem_req_t memReq_ff,
	output logic [MaxBytes-1:0][7:0] rxBuf_ff,
	output logic [2:0] fuseBlow_ff,
	output ccf_mode_t commMode_ff,
	output ccf_card_t cardState_ff
);
	localparam int TxBytes = 6;

	if (MaxBytes < 8 || MaxBytes > 36 || LinkTimeoutCyc < 2 || LinkTimeoutCyc > 65535)
	begin : gBadParam
		$error("ccf_front_end: parameter out of range");
	end

	function automatic logic [15:0] crcByte(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c ^ {8'h00, d};
		for (int i = 0; i < 8; i++)
			r = r[0] ? ((r >> 1) ^ `CCF_CRC_POLY) : (r >> 1);
		return r;
	endfunction

	// Pin synchronisers: field, link clock, receive data, Type A detect
	logic [3:0] syncA_ff;
	logic [3:0] syncB_ff;
	logic linkPrev_ff;
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			syncA_ff <= 4'h0;
			syncB_ff <= 4'h0;
			linkPrev_ff <= 1'b0;
		end
		else
		begin
			syncA_ff <= {fieldOn, linkClk, rxBit, typeAMod};
			syncB_ff <= syncA_ff;
			linkPrev_ff <= syncB_ff[2];
		end
	end
	logic pwrDown;
	logic rxLvl;
	logic typeA;
	logic bitEdge;
	assign pwrDown = reset | ~syncB_ff[3];
	assign rxLvl = syncB_ff[1];
	assign typeA = syncB_ff[0];
	assign bitEdge = syncB_ff[2] & ~linkPrev_ff;

	ccf_rx_t rxState_ff;
	ccf_tx_t txState_ff;
	logic [3:0] lowCnt_ff;
	logic [3:0] bitCnt_ff;
	logic [7:0] shift_ff;
	logic [5:0] rxCnt_ff;
	logic rxOvf_ff;
	logic [15:0] rxCrc_ff;
	logic frameEnd_ff;
	logic [15:0] tmoCnt_ff;
	logic tmo;
	logic abortRx;
	logic byteDone;

	// A stalled link clock or Type A modulation must not leave a frame hanging
	assign tmo = (tmoCnt_ff == 16'(LinkTimeoutCyc - 1));
	assign abortRx = pwrDown | typeA | txActive_ff | tmo;
	assign byteDone = bitEdge & (rxState_ff == RX_BITS) & (bitCnt_ff == 4'h8) & rxLvl;

	always_ff @(posedge ref_clk)
	begin
		if (pwrDown || bitEdge || (rxState_ff == RX_IDLE && !txActive_ff))
			tmoCnt_ff <= 16'h0000;
		else if (!tmo)
			tmoCnt_ff <= tmoCnt_ff + 16'h0001;
	end

	// Character receiver: SOF, start bit, 8 data bits LSB first, stop bit, EOF
	always_ff @(posedge ref_clk)
	begin
		frameEnd_ff <= 1'b0;
		if (abortRx)
		begin
			rxState_ff <= RX_IDLE;
			lowCnt_ff <= 4'h0;
			bitCnt_ff <= 4'h0;
			shift_ff <= 8'h00;
			rxCnt_ff <= 6'h00;
			rxOvf_ff <= 1'b0;
			rxCrc_ff <= `CCF_CRC_INIT;
		end
		else if (bitEdge)
		begin
			unique case (rxState_ff)
				RX_IDLE:
				begin
					if (!rxLvl)
						lowCnt_ff <= (lowCnt_ff == 4'hF) ? 4'hF : lowCnt_ff + 4'h1;
					else
					begin
						if (lowCnt_ff >= `CCF_SOF_LOW_BITS)
						begin
							rxState_ff <= RX_WAIT;
							rxCnt_ff <= 6'h00;
							rxOvf_ff <= 1'b0;
							rxCrc_ff <= `CCF_CRC_INIT;
						end
						lowCnt_ff <= 4'h0;
					end
				end
				RX_WAIT:
				begin
					if (!rxLvl)
					begin
						rxState_ff <= RX_BITS;
						bitCnt_ff <= 4'h0;
					end
				end
				RX_BITS:
				begin
					if (bitCnt_ff != 4'h8)
					begin
						shift_ff <= {rxLvl, shift_ff[7:1]};
						bitCnt_ff <= bitCnt_ff + 4'h1;
					end
					else if (rxLvl)
					begin
						// Only data bytes enter the CRC; framing bits never do
						rxCrc_ff <= crcByte(rxCrc_ff, shift_ff);
						rxState_ff <= RX_WAIT;
						if (rxCnt_ff < 6'(MaxBytes))
							rxCnt_ff <= rxCnt_ff + 6'h01;
						else
							rxOvf_ff <= 1'b1;
					end
					else
					begin
						rxState_ff <= RX_IDLE;
						frameEnd_ff <= (shift_ff == 8'h00);
					end
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (pwrDown)
			rxBuf_ff <= '0;
		else if (byteDone && !abortRx && rxCnt_ff < 6'(MaxBytes))
			rxBuf_ff[rxCnt_ff] <= shift_ff;
	end

	// Frame decode
	logic crcOk;
	logic frameOk;
	logic [5:0] dataLen;
	logic [7:0] cmd;
	logic idMatch;
	logic isPoll;
	logic wup;
	logic afiOk;
	logic pollGo;
	logic haltGo;
	logic attribGo;
	logic propCmd;
	logic pageOk;
	logic [7:0] lockEnd;
	logic [1:0] fuseIdx;
	logic fuseOk;
	logic [7:0] propStatus;
	assign crcOk = (rxCrc_ff == `CCF_CRC_RESIDUE);
	assign frameOk = frameEnd_ff & crcOk & ~rxOvf_ff & (rxCnt_ff > `CCF_CRC_BYTES);
	assign dataLen = rxCnt_ff - `CCF_CRC_BYTES;
	assign cmd = rxBuf_ff[0];
	assign idMatch = ({rxBuf_ff[1], rxBuf_ff[2], rxBuf_ff[3], rxBuf_ff[4]} == cardId);
	assign isPoll = frameOk & (cmd == `CCF_APF) & (dataLen == 6'h03);
	assign wup = rxBuf_ff[2][`CCF_WUP_BIT];
	assign afiOk = (rxBuf_ff[1] == 8'h00) | (rxBuf_ff[1] == cfgAfi);
	assign pollGo = isPoll & afiOk & ((cardState_ff == CS_IDLE) | (cardState_ff == CS_READY)
		| ((cardState_ff == CS_HALT) & wup));
	assign haltGo = frameOk & (cmd == `CCF_CMD_HALT) & (dataLen == 6'h05) & idMatch
		& ((cardState_ff == CS_READY) | (cardState_ff == CS_ACTIVE));
	assign attribGo = frameOk & (cmd == `CCF_CMD_ATTRIB) & (dataLen >= 6'h05) & idMatch
		& (cardState_ff == CS_READY);
	assign propCmd = frameOk & (cardState_ff == CS_ACTIVE) & ((cmd == `CCF_CMD_READ)
		| (cmd == `CCF_CMD_WRITE) | (cmd == `CCF_CMD_CFG_READ) | (cmd == `CCF_CMD_CFG_WRITE)
		| (cmd == `CCF_CMD_FUSE));
	// Zone in byte 1, in-zone address in byte 2, length in byte 3
	assign pageOk = (rxBuf_ff[3] != 8'h00) & ({1'b0, rxBuf_ff[3]} <= `CCF_PAGE_BYTES)
		& (({4'h0, rxBuf_ff[2][4:0]} + {1'b0, rxBuf_ff[3]}) <= `CCF_PAGE_BYTES);
	assign lockEnd = fuseBlown[2] ? `CCF_FUSE2_END : fuseBlown[1] ? `CCF_FUSE1_END
		: fuseBlown[0] ? `CCF_FUSE0_END : 8'h00;
	assign fuseIdx = rxBuf_ff[1][1:0];
	assign fuseOk = (fuseIdx == 2'h0) ? ~fuseBlown[0] : (fuseIdx == 2'h1)
		? (fuseBlown[0] & ~fuseBlown[1]) : (fuseIdx == 2'h2)
		? (fuseBlown[0] & fuseBlown[1] & ~fuseBlown[2]) : 1'b0;

	always_comb
	begin
		propStatus = `CCF_ST_ACK;
		if (cmd == `CCF_CMD_FUSE)
			propStatus = fuseOk ? `CCF_ST_ACK : `CCF_ST_FUSE;
		else if (!pageOk)
			propStatus = `CCF_ST_PAGE;
		else if ((cmd == `CCF_CMD_WRITE || cmd == `CCF_CMD_CFG_WRITE)
			&& {2'b00, dataLen} != rxBuf_ff[3] + 8'h04)
			propStatus = `CCF_ST_LEN;
		else if (cmd == `CCF_CMD_READ && !zoneReadOk[rxBuf_ff[1][3:0]])
			propStatus = `CCF_ST_SEC;
		else if (cmd == `CCF_CMD_WRITE && !zoneWriteOk[rxBuf_ff[1][3:0]])
			propStatus = `CCF_ST_SEC;
		else if (cmd == `CCF_CMD_CFG_WRITE && (!cfgWriteOk || rxBuf_ff[2] < lockEnd))
			propStatus = `CCF_ST_SEC;
	end

	// Card state: power-on, anti-tearing, idle, ready, active, halt
	always_ff @(posedge ref_clk)
	begin
		if (pwrDown)
		begin
			cardState_ff <= CS_OFF;
			tearReq_ff <= 1'b0;
			commMode_ff <= MODE_STANDARD;
		end
		else
		begin
			unique case (cardState_ff)
				CS_OFF:
				begin
					cardState_ff <= CS_TEAR;
					tearReq_ff <= 1'b1;
				end
				CS_TEAR:
				begin
					if (tearDone)
					begin
						cardState_ff <= CS_IDLE;
						tearReq_ff <= 1'b0;
					end
				end
				CS_IDLE, CS_READY, CS_ACTIVE, CS_HALT:
				begin
					if (pollGo)
						cardState_ff <= CS_READY;
					else if (haltGo)
						cardState_ff <= CS_HALT;
					else if (attribGo)
					begin
						cardState_ff <= CS_ACTIVE;
						commMode_ff <= MODE_STANDARD;
					end
				end
			endcase
		end
	end

	// Requests to the memory engine and fuse programmer
	always_ff @(posedge ref_clk)
	begin
		memReq_ff.valid <= 1'b0;
		fuseBlow_ff <= 3'h0;
		if (pwrDown)
			memReq_ff <= '0;
		else if (propCmd && propStatus == `CCF_ST_ACK)
		begin
			if (cmd == `CCF_CMD_FUSE)
				fuseBlow_ff <= 3'(3'h1 << fuseIdx);
			else
			begin
				memReq_ff.valid <= 1'b1;
				memReq_ff.write <= (cmd == `CCF_CMD_WRITE) | (cmd == `CCF_CMD_CFG_WRITE);
				memReq_ff.cfg <= (cmd == `CCF_CMD_CFG_READ) | (cmd == `CCF_CMD_CFG_WRITE);
				memReq_ff.zone <= rxBuf_ff[1][3:0];
				memReq_ff.addr <= rxBuf_ff[2];
				memReq_ff.len <= rxBuf_ff[3][5:0];
			end
		end
	end

	// Reply assembly; a frame with a bad CRC reaches none of these branches
	logic [TxBytes-1:0][7:0] txBuf_ff;
	logic [3:0] txLen_ff;
	logic txPend_ff;
	always_ff @(posedge ref_clk)
	begin
		if (pwrDown || (txState_ff == TX_IDLE && bitEdge))
			txPend_ff <= 1'b0;
		if (pwrDown)
		begin
			txBuf_ff <= '0;
			txLen_ff <= 4'h0;
		end
		else if (pollGo)
		begin
			txBuf_ff <= {cfgAfi, cardId[7:0], cardId[15:8], cardId[23:16], cardId[31:24],
				`CCF_ATQB_HDR};
			txLen_ff <= 4'(TxBytes);
			txPend_ff <= 1'b1;
		end
		else if (haltGo || attribGo || propCmd)
		begin
			txBuf_ff <= {40'h00_0000_0000, propCmd ? propStatus : `CCF_ST_ACK};
			txLen_ff <= 4'h1;
			txPend_ff <= 1'b1;
		end
	end

	// Transmitter: SOF, bytes with start/stop, CRC low then high byte, EOF
	logic [3:0] txCnt_ff;
	logic [3:0] txIdx_ff;
	logic [7:0] txSh_ff;
	logic [15:0] txCrc_ff;
	logic [7:0] curByte;
	assign curByte = (txIdx_ff < txLen_ff) ? txBuf_ff[txIdx_ff[2:0]] : (txIdx_ff == txLen_ff)
		? ~txCrc_ff[7:0] : ~txCrc_ff[15:8];
	always_ff @(posedge ref_clk)
	begin
		if (pwrDown || tmo)
		begin
			txState_ff <= TX_IDLE;
			txActive_ff <= 1'b0;
			txBit_ff <= 1'b1;
			txCnt_ff <= 4'h0;
			txIdx_ff <= 4'h0;
			txSh_ff <= 8'h00;
			txCrc_ff <= `CCF_CRC_INIT;
		end
		else if (bitEdge)
		begin
			unique case (txState_ff)
				TX_IDLE:
				begin
					if (txPend_ff)
					begin
						txState_ff <= TX_SOF;
						txActive_ff <= 1'b1;
						txCnt_ff <= 4'h0;
						txIdx_ff <= 4'h0;
						txCrc_ff <= `CCF_CRC_INIT;
					end
				end
				TX_SOF:
				begin
					txBit_ff <= (txCnt_ff >= `CCF_SOF_LOW_BITS);
					txCnt_ff <= (txCnt_ff == `CCF_SOF_BITS - 4'h1) ? 4'h0 : txCnt_ff + 4'h1;
					if (txCnt_ff == `CCF_SOF_BITS - 4'h1)
						txState_ff <= TX_CHAR;
				end
				TX_CHAR:
				begin
					txCnt_ff <= txCnt_ff + 4'h1;
					if (txCnt_ff == 4'h0)
					begin
						txBit_ff <= 1'b0;
						txSh_ff <= curByte;
						if (txIdx_ff < txLen_ff)
							txCrc_ff <= crcByte(txCrc_ff, curByte);
					end
					else if (txCnt_ff != `CCF_CHAR_BITS - 4'h1)
					begin
						txBit_ff <= txSh_ff[0];
						txSh_ff <= {1'b0, txSh_ff[7:1]};
					end
					else
					begin
						txBit_ff <= 1'b1;
						txCnt_ff <= 4'h0;
						txIdx_ff <= txIdx_ff + 4'h1;
						if (txIdx_ff == txLen_ff + 4'h1)
							txState_ff <= TX_EOF;
					end
				end
				TX_EOF:
				begin
					txCnt_ff <= txCnt_ff + 4'h1;
					txBit_ff <= (txCnt_ff == `CCF_EOF_LOW_BITS);
					if (txCnt_ff == `CCF_EOF_LOW_BITS)
					begin
						txState_ff <= TX_IDLE;
						txActive_ff <= 1'b0;
					end
				end
			endcase
		end
	end

	// Checks
	logic [15:0] zrPast_ff;
	logic [15:0] zwPast_ff;
	always_ff @(posedge ref_clk)
	begin
		zrPast_ff <= zoneReadOk;
		zwPast_ff <= zoneWriteOk;
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	silentPor_a: assert property (
		(cardState_ff == CS_OFF || cardState_ff == CS_TEAR) |-> !txPend_ff && !txActive_ff)
	else $error("card transmits before power-on completes");
	tearFirst_a: assert property (
		$rose(cardState_ff == CS_IDLE) |-> $past(tearReq_ff) && $past(tearDone))
	else $error("idle entered without anti-tearing evaluation");
	wupHalt_a: assert property (
		isPoll && wup && afiOk && cardState_ff == CS_HALT && !pwrDown
		|=> cardState_ff == CS_READY && txPend_ff)
	else $error("wake-up poll did not activate halted card");
	reqHalt_a: assert property (
		isPoll && !wup && cardState_ff == CS_HALT && !pwrDown
		|=> cardState_ff == CS_HALT && !txPend_ff)
	else $error("request poll disturbed halted card");
	propGate_a: assert property (
		memReq_ff.valid || fuseBlow_ff != 3'h0 |-> $past(cardState_ff) == CS_ACTIVE)
	else $error("memory command accepted before anticollision");
	pageEnd_a: assert property (
		memReq_ff.valid |-> memReq_ff.len != 6'h00
		&& ({4'h0, memReq_ff.addr[4:0]} + {3'b000, memReq_ff.len}) <= 9'h020)
	else $error("memory access crosses a page end");
	zoneSec_a: assert property (
		memReq_ff.valid && !memReq_ff.cfg |-> (memReq_ff.write
		? zwPast_ff[memReq_ff.zone] : zrPast_ff[memReq_ff.zone]))
	else $error("zone access issued without its rights");
	fuseTwo_a: assert property (
		fuseBlow_ff[1] |-> ($past(fuseBlown) & 3'h1) == 3'h1)
	else $error("second fuse blown before the first");
	fuseThree_a: assert property (
		fuseBlow_ff[2] |-> ($past(fuseBlown) & 3'h3) == 3'h3)
	else $error("third fuse blown out of order");
	crcDrop_a: assert property (
		frameEnd_ff && !crcOk && !pwrDown |=> !txPend_ff && $stable(cardState_ff))
	else $error("frame with bad CRC changed state or got a reply");
	halfDup_a: assert property (
		txActive_ff |-> rxState_ff == RX_IDLE [*2])
	else $error("receiver busy while transmitting");

	pollAns_c: cover property (pollGo ##[1:1000] txActive_ff);
	attrib_c: cover property (attribGo ##1 cardState_ff == CS_ACTIVE);
	memWrite_c: cover property (memReq_ff.valid && memReq_ff.write);
	fuseBlow_c: cover property (fuseBlow_ff[2]);
endmodule

// >>> testbench/ccf_reader_model.sv
// Reader model: frames commands on the link and collects the card's reply
module ccf_reader_model
(
	output logic linkClk,
	output logic rxBit,
	input wire logic txBit,
	input wire logic txActive
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [7:0] rxq[$];
	logic frameOk;
	logic lastTx;
	logic lastAct;

	initial
	begin
		linkClk = 1'b0;
		rxBit = 1'b1;
		lastAct = 1'b0;
	end

	function automatic logic [15:0] crcB(input logic [7:0] q[$]);
		logic [15:0] c;
		c = 16'hFFFF;
		foreach (q[i])
		begin
			c = c ^ {8'h00, q[i]};
			for (int b = 0; b < 8; b++)
				c = c[0] ? ((c >> 1) ^ 16'h8408) : (c >> 1);
		end
		return ~c;
	endfunction

	// Card line sampled just before each rising edge, once its update has landed
	task automatic linkBit(input logic b);
		rxBit = b;
		#31 lastTx = txBit;
		lastAct = txActive;
		#1 linkClk = 1'b1;
		#32 linkClk = 1'b0;
	endtask

	task automatic sendFrame(input logic [7:0] q[$], input logic badCrc);
		logic [15:0] c;
		logic [7:0] f[$];
		c = crcB(q) ^ {15'h0, badCrc};
		f = q;
		f.push_back(c[7:0]);
		f.push_back(c[15:8]);
		repeat (10) linkBit(1'b0);
		repeat (2) linkBit(1'b1);
		foreach (f[i])
		begin
			linkBit(1'b0);
			for (int b = 0; b < 8; b++)
				linkBit(f[i][b]);
			linkBit(1'b1);
		end
		repeat (10) linkBit(1'b0);
	endtask

	task automatic listen(output logic got);
		logic bits[$];
		logic [7:0] d;
		logic [15:0] c;
		int n;
		int i;
		int z;
		rxq = {};
		frameOk = 1'b0;
		n = 0;
		while (lastAct !== 1'b1 && n < 16)
		begin
			linkBit(1'b1);
			n++;
		end
		got = (lastAct === 1'b1);
		while (lastAct === 1'b1 && n < 1200)
		begin
			bits.push_back(lastTx);
			linkBit(1'b1);
			n++;
		end
		i = 0;
		while (i < bits.size() && bits[i] === 1'b1)
			i++;
		z = i;
		while (i < bits.size() && bits[i] === 1'b0)
			i++;
		frameOk = (i - z == 10);
		z = i;
		while (i < bits.size() && bits[i] === 1'b1)
			i++;
		frameOk = frameOk && (i - z == 2);
		while (i + 10 <= bits.size() && bits[i + 9] === 1'b1)
		begin
			for (int b = 0; b < 8; b++)
				d[b] = bits[i + 1 + b];
			frameOk = frameOk && bits[i] === 1'b0;
			rxq.push_back(d);
			i += 10;
		end
		frameOk = frameOk && (bits.size() - i == 10);
		for (int k = i; k < bits.size(); k++)
			frameOk = frameOk && bits[k] === 1'b0;
		if (rxq.size() < 3)
			frameOk = 1'b0;
		else
		begin
			c = crcB(rxq[0:$-2]);
			frameOk = frameOk && (c === {rxq[$], rxq[$-1]});
			rxq = rxq[0:$-2];
		end
	endtask

	task automatic xfer(input logic [7:0] q[$], input logic badCrc, output logic got);
		sendFrame(q, badCrc);
		listen(got);
	endtask
endmodule

// >>> testbench/tb_top.sv
// Testbench of the card front end: power-up, polling, framing, memory and fuse gating
`define CHK(gotv, expv) \
	begin \
		totalChecks++; \
		if ((gotv) !== (expv)) \
		begin \
			errCount++; \
			$display("[ERR] %0t got %0h exp %0h", $time, (gotv), (expv)); \
		end \
	end

module tb_top
	import ccf_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic ref_clk;
	logic reset;
	logic fieldOn;
	logic typeAMod;
	logic tearDone;
	logic [7:0] cfgAfi;
	logic [31:0] cardId;
	logic [15:0] zoneReadOk;
	logic [15:0] zoneWriteOk;
	logic cfgWriteOk;
	logic [2:0] fuseBlown;
	logic linkClk;
	logic rxBit;
	logic txBit;
	logic txActive;
	logic tearReq;
	ccf_mem_req_t memReq;
	ccf_mem_req_t memSeen;
	logic [2:0] fuseBlow;
	logic [2:0] fuseSeen;
	ccf_mode_t commMode;
	ccf_card_t cardState;
	logic [35:0][7:0] rxBuf;
	logic got;
	int memCnt = 0;
	int fuseCnt = 0;
	int errCount = 0;
	int totalChecks = 0;

	ccf_front_end #(.MaxBytes(36), .LinkTimeoutCyc(200)) dut_u (
		.ref_clk(ref_clk), .reset(reset), .fieldOn(fieldOn), .linkClk(linkClk),
		.rxBit(rxBit), .typeAMod(typeAMod), .tearDone(tearDone), .cfgAfi(cfgAfi),
		.cardId(cardId), .zoneReadOk(zoneReadOk), .zoneWriteOk(zoneWriteOk),
		.cfgWriteOk(cfgWriteOk), .fuseBlown(fuseBlown), .txBit_ff(txBit),
		.txActive_ff(txActive), .tearReq_ff(tearReq), .memReq_ff(memReq), .rxBuf_ff(rxBuf),
		.fuseBlow_ff(fuseBlow), .commMode_ff(commMode), .cardState_ff(cardState)
	);

	ccf_reader_model rdr (
		.linkClk(linkClk), .rxBit(rxBit), .txBit(txBit), .txActive(txActive)
	);

	always #4 ref_clk = ~ref_clk;

	// Records one-cycle request pulses for later comparison
	always @(posedge ref_clk)
	begin
		if (!reset && memReq.valid === 1'b1)
		begin
			memSeen <= memReq;
			memCnt <= memCnt + 1;
		end
		if (!reset && |fuseBlow === 1'b1)
		begin
			fuseSeen <= fuseBlow;
			fuseCnt <= fuseCnt + 1;
		end
	end

	task automatic endSim();
		if (errCount == 0 && totalChecks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic poll(input logic [7:0] afi, input logic wake);
		rdr.xfer('{8'h05, afi, wake ? 8'h08 : 8'h00}, 1'b0, got);
	endtask

	task automatic xferId(input logic [7:0] op);
		rdr.xfer('{op, cardId[31:24], cardId[23:16], cardId[15:8], cardId[7:0]}, 1'b0, got);
	endtask

	task automatic expectStatus(input logic [7:0] s);
		`CHK(got, 1'b1)
		`CHK(rdr.frameOk, 1'b1)
		`CHK(rdr.rxq[0], s)
	endtask

	task automatic expectAtqb();
		logic [47:0] r;
		r = {rdr.rxq[0], rdr.rxq[1], rdr.rxq[2], rdr.rxq[3], rdr.rxq[4], rdr.rxq[5]};
		`CHK(got, 1'b1)
		`CHK(rdr.frameOk, 1'b1)
		`CHK(rdr.rxq.size(), 6)
		`CHK(r, {8'h50, cardId, cfgAfi})
	endtask

	task automatic powerUp();
		repeat (3) @(negedge ref_clk);
		`CHK(cardState, CS_TEAR)
		`CHK(tearReq, 1'b1)
		poll(8'h00, 1'b1);
		`CHK(got, 1'b0)
		`CHK(txBit, 1'b1)
		@(negedge ref_clk);
		tearDone = 1'b1;
		repeat (3) @(negedge ref_clk);
		`CHK(cardState, CS_IDLE)
		`CHK(tearReq, 1'b0)
	endtask

	task automatic idleGating();
		rdr.xfer('{8'h02, 8'h0F, 8'hE0, 8'h01}, 1'b0, got);
		`CHK(got, 1'b0)
		rdr.xfer('{8'h05, 8'h42, 8'h08}, 1'b1, got);
		`CHK(got, 1'b0)
		`CHK(cardState, CS_IDLE)
		@(negedge ref_clk);
		typeAMod = 1'b1;
		poll(8'h42, 1'b1);
		`CHK(got, 1'b0)
		@(negedge ref_clk);
		typeAMod = 1'b0;
		`CHK(memCnt, 0)
	endtask

	task automatic polling();
		poll(8'h17, 1'b1);
		`CHK(got, 1'b0)
		poll(8'h42, 1'b0);
		expectAtqb();
		`CHK(cardState, CS_READY)
	endtask

	task automatic haltWake();
		xferId(8'h50);
		expectStatus(8'h00);
		`CHK(cardState, CS_HALT)
		poll(8'h42, 1'b0);
		`CHK(got, 1'b0)
		`CHK(cardState, CS_HALT)
		poll(8'h00, 1'b1);
		expectAtqb();
		`CHK(cardState, CS_READY)
	endtask

	task automatic activate();
		rdr.xfer('{8'h02, 8'h0F, 8'hE0, 8'h01}, 1'b0, got);
		`CHK(got, 1'b0)
		xferId(8'h1D);
		expectStatus(8'h00);
		`CHK(cardState, CS_ACTIVE)
		`CHK(commMode, MODE_STANDARD)
	endtask

	task automatic memAccess();
		rdr.xfer('{8'h02, 8'h0F, 8'hE0, 8'h20}, 1'b0, got);
		expectStatus(8'h00);
		`CHK(memSeen, {1'b1, 1'b0, 1'b0, 4'hF, 8'hE0, 6'h20})
		rdr.xfer('{8'h02, 8'h03, 8'hE0, 8'h20}, 1'b0, got);
		expectStatus(8'h02);
		rdr.xfer('{8'h03, 8'h02, 8'h1F, 8'h02, 8'hAA, 8'h55}, 1'b0, got);
		expectStatus(8'h01);
		rdr.xfer('{8'h03, 8'h02, 8'h1E, 8'h02, 8'hAA}, 1'b0, got);
		expectStatus(8'h04);
		`CHK(memCnt, 1)
		rdr.xfer('{8'h03, 8'h02, 8'h1E, 8'h02, 8'hAA, 8'h55}, 1'b0, got);
		expectStatus(8'h00);
		`CHK(memSeen, {1'b1, 1'b1, 1'b0, 4'h2, 8'h1E, 6'h02})
		`CHK(rxBuf[5:4], 16'h55AA)
	endtask

	task automatic fuseOrder();
		rdr.xfer('{8'h04, 8'h01}, 1'b0, got);
		expectStatus(8'h03);
		`CHK(fuseCnt, 0)
		rdr.xfer('{8'h04, 8'h00}, 1'b0, got);
		expectStatus(8'h00);
		`CHK(fuseSeen, 3'h1)
		@(negedge ref_clk);
		fuseBlown = 3'h1;
		rdr.xfer('{8'h07, 8'h00, 8'h10, 8'h01, 8'h3C}, 1'b0, got);
		expectStatus(8'h02);
		`CHK(memCnt, 2)
		rdr.xfer('{8'h07, 8'h00, 8'h40, 8'h01, 8'h3C}, 1'b0, got);
		expectStatus(8'h00);
		`CHK(memSeen, {1'b1, 1'b1, 1'b1, 4'h0, 8'h40, 6'h01})
		rdr.xfer('{8'h06, 8'h00, 8'h00, 8'h01}, 1'b0, got);
		expectStatus(8'h00);
		`CHK(memSeen, {1'b1, 1'b0, 1'b1, 4'h0, 8'h00, 6'h01})
		rdr.xfer('{8'h04, 8'h02}, 1'b0, got);
		expectStatus(8'h03);
		rdr.xfer('{8'h04, 8'h01}, 1'b0, got);
		expectStatus(8'h00);
		`CHK(fuseSeen, 3'h2)
		@(negedge ref_clk);
		fuseBlown = 3'h3;
		rdr.xfer('{8'h04, 8'h02}, 1'b0, got);
		expectStatus(8'h00);
		`CHK(fuseSeen, 3'h4)
		`CHK(fuseCnt, 3)
	endtask

	task automatic fieldCycle();
		@(negedge ref_clk);
		fieldOn = 1'b0;
		repeat (4) @(negedge ref_clk);
		`CHK(cardState, CS_OFF)
		`CHK(tearReq, 1'b0)
		fieldOn = 1'b1;
		repeat (3) @(negedge ref_clk);
		`CHK(cardState, CS_TEAR)
		@(negedge ref_clk);
		`CHK(cardState, CS_IDLE)
		rdr.xfer('{8'h02, 8'h0F, 8'hE0, 8'h01}, 1'b0, got);
		`CHK(got, 1'b0)
		`CHK(commMode, MODE_STANDARD)
	endtask

	initial
	begin
		ref_clk = 1'b0;
		reset = 1'b1;
		fieldOn = 1'b1;
		typeAMod = 1'b0;
		tearDone = 1'b0;
		cfgAfi = 8'h42;
		cardId = 32'hA5C3_1E7B;
		zoneReadOk = 16'h8000;
		zoneWriteOk = 16'h0004;
		cfgWriteOk = 1'b1;
		fuseBlown = 3'h0;
		repeat (10) @(negedge ref_clk);
		reset = 1'b0;
		powerUp();
		idleGating();
		polling();
		haltWake();
		activate();
		memAccess();
		fuseOrder();
		fieldCycle();
		endSim();
	end

	// Cuts a hang short
	initial
	begin
		#700000;
		errCount++;
		endSim();
	end
endmodule
